/* File: hdl/mac_if_cfg_pkg.sv */
// package: register map, field layout and types of the mac interface config
package mac_if_cfg_pkg;

    // register index and its aligned byte address on the apb bus
    localparam logic [7:0]  REG_INDEX  = 8'h17;
    localparam logic [7:0]  REG_ADDR   = REG_INDEX << 2;

    // field positions of the read-clear status bits and the rmii mode bit
    localparam int          BIT_OVF    = 3;
    localparam int          BIT_UDF    = 2;
    localparam int          BIT_RMII   = 5;

    // reset value: fifo normal operation, elasticity select 01, mii mode
    localparam logic [15:0] REG_RESET  = 16'h0041;
    // bits that software may write
    localparam logic [15:0] RW_MASK    = 16'h1FF3;

    // elasticity tolerance in bits for each select code
    localparam logic [3:0]  TOL_SEL_00 = 4'hE;
    localparam logic [3:0]  TOL_SEL_01 = 4'h2;
    localparam logic [3:0]  TOL_SEL_10 = 4'h6;
    localparam logic [3:0]  TOL_SEL_11 = 4'hA;

    // configuration fields carried into the link domain
    typedef struct packed {
        logic       rx_clk_shift;
        logic       tx_clk_shift_off;
        logic       shared_clk;
        logic       rgmii_mode;
        logic       rmii_tx_shift;
        logic       ref_clk_50m;
        logic       fifo_normal;
        logic       rmii_mode;
        logic       rev_1p0;
        logic [1:0] elastic_sel;
    } cfg_type;

    // full register layout, msb first
    typedef struct packed {
        logic [2:0] resv;
        logic       rx_clk_shift;
        logic       tx_clk_shift_off;
        logic       shared_clk;
        logic       rgmii_mode;
        logic       rmii_tx_shift;
        logic       ref_clk_50m;
        logic       fifo_normal;
        logic       rmii_mode;
        logic       rev_1p0;
        logic       ovf;
        logic       udf;
        logic [1:0] elastic_sel;
    } ctl_type;

    // mac interface selection, one-hot
    typedef enum logic [2:0] {
        MODE_MII   = 3'h1,
        MODE_RMII  = 3'h2,
        MODE_RGMII = 3'h4
    } mode_type;

endpackage : mac_if_cfg_pkg

/* File: hdl/mac_interface_mode_config.sv */
// mac interface mode configuration and status register with apb slave
// How it works
// - rx clock shift bit delays rx clock
// - tx shift bit zero enables delay
// - bit ten selects shared clock mode
// - strapped bit nine enables rgmii mode
// - bit five picks rmii, else mii
// - bit eight shifts rmii transmit clock
// - strapped bit seven selects reference clock
// - bit six zero bypasses receive fifo in rmii mode
// - fifo bypass drives 50 mhz rx clock
// - revision 1.0 holds crs_dv until done
// - revision 1.2 toggles crs_dv at end
// - overflow flag set, cleared by read
// - underflow flag set, cleared by read
// - bits 1:0 select elasticity tolerance
module mac_interface_mode_config
    import mac_if_cfg_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_strap_rgmii,
    input  wire logic        i_reference_clock_select_strap,
    input  wire logic        i_link_clk,
    input  wire logic        i_link_ovf,
    input  wire logic        i_link_udf,
    input  wire logic        i_link_crs,
    input  wire logic        i_link_rx_dv,
    output mode_type         o_if_mode,
    output logic             o_rx_clk_shift_en,
    output logic             o_tx_clk_shift_en,
    output logic             o_rgmii_shared_clk,
    output logic             o_rmii_tx_clk_shift_en,
    output logic             o_ref_clk_50m,
    output logic             o_rx_fifo_bypass,
    output logic             o_rx_clk_50m_out,
    output logic             o_crs_dv,
    output logic [3:0]       o_elastic_tol_bits
);

    // elasticity select code to tolerance in bits
    function automatic logic [3:0] tol_bits(input logic [1:0] sel);
        logic [3:0] t;
        t = TOL_SEL_01;
        case (sel)
            2'h0:    t = TOL_SEL_00;
            2'h1:    t = TOL_SEL_01;
            2'h2:    t = TOL_SEL_10;
            2'h3:    t = TOL_SEL_11;
            default: t = TOL_SEL_01;
        endcase
        return t;
    endfunction : tol_bits

    // ---------------- system clock domain ----------------
    ctl_type     reg_r;
    ctl_type     reg_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic [1:0]  strap_s1_r;
    logic [1:0]  strap_s2_r;
    logic [1:0]  strap_s3_r;
    logic        strap_pend_r;
    logic [1:0]  evt_s1_r;
    logic [1:0]  evt_s2_r;
    logic [1:0]  evt_s3_r;
    logic [1:0]  evt_seen_r;
    // link domain toggles, declared here because the sync chain reads them
    logic [1:0]  link_tgl_r;

    // bus decode
    wire logic        setup    = i_psel & ~i_penable;
    wire logic        hit      = (i_paddr == REG_ADDR);
    wire logic        done     = i_psel & i_penable & pready_r;
    wire logic        wr_go    = done & i_pwrite & hit;
    wire logic        rd_clr   = done & ~i_pwrite & hit;

    // strap levels count once the second and third stage agree
    wire logic        strap_ok = (strap_s2_r == strap_s3_r);
    wire logic        strap_ld = strap_pend_r & strap_ok;

    // toggle events from the link side, accepted on agreement
    wire logic [1:0]  evt_agree = ~(evt_s2_r ^ evt_s3_r);
    wire logic [1:0]  evt       = evt_agree & (evt_s3_r ^ evt_seen_r);

    // only bits that were actually reported get cleared by the read
    wire logic        clr_ovf  = rd_clr & prdata_r[BIT_OVF];
    wire logic        clr_udf  = rd_clr & prdata_r[BIT_UDF];

    // register next state
    wire logic [15:0] wr_val   = (i_pwdata[15:0] & RW_MASK)
                               | (reg_r & ~RW_MASK);
    always_comb begin
        reg_nxt = reg_r;
        if (wr_go) begin
            reg_nxt = wr_val;
        end
        if (strap_ld) begin
            reg_nxt.rgmii_mode  = strap_s3_r[1];
            reg_nxt.ref_clk_50m = strap_s3_r[0];
        end
        reg_nxt.resv = 3'h0;
        reg_nxt.ovf  = (reg_r.ovf & ~clr_ovf) | evt[1];
        reg_nxt.udf  = (reg_r.udf & ~clr_udf) | evt[0];
    end

    // read data captured in setup so it can leave a flop in access
    assign prdata_nxt  = (setup & hit) ? {16'h0000, reg_r} : 32'h0000_0000;
    assign pready_nxt  = setup;
    assign pslverr_nxt = setup & ~hit;

    // register and bus answer flops
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            reg_r     <= REG_RESET;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            reg_r     <= reg_nxt;
            prdata_r  <= setup ? prdata_nxt : prdata_r;
            pready_r  <= pready_nxt;
            pslverr_r <= setup ? pslverr_nxt : pslverr_r;
        end
    end

    // strap capture armed by reset, done after release
    always_ff @(posedge i_clk) begin
        strap_s1_r <= {i_strap_rgmii, i_reference_clock_select_strap};
        strap_s2_r <= strap_s1_r;
        strap_s3_r <= strap_s2_r;
        if (i_rst) begin
            strap_pend_r <= 1'b1;
        end else if (strap_ok) begin
            strap_pend_r <= 1'b0;
        end
    end

    // event toggle synchroniser into the system domain
    always_ff @(posedge i_clk) begin
        evt_s1_r <= link_tgl_r;
        evt_s2_r <= evt_s1_r;
        evt_s3_r <= evt_s2_r;
        if (i_rst) begin
            evt_seen_r <= evt_s3_r & evt_agree;
        end else begin
            evt_seen_r <= evt_seen_r ^ evt;
        end
    end

    assign o_prdata  = prdata_r;
    assign o_pready  = pready_r;
    assign o_pslverr = pslverr_r;

    // ---------------- link clock domain ----------------
    logic [2:0]  rst_l_s_r;
    logic        rst_l_r;
    logic [10:0] cfg_s1_r;
    logic [10:0] cfg_s2_r;
    logic [10:0] cfg_s3_r;
    cfg_type     cfg_l_r;
    mode_type    mode_r;
    logic        rx_shift_r;
    logic        tx_shift_r;
    logic        shared_r;
    logic        rmii_tx_shift_r;
    logic        ref50_r;
    logic        bypass_r;
    logic        clk50_r;
    logic        crs_dv_r;
    logic        crs_dv_nxt;
    logic [3:0]  tol_r;

    // config vector as seen by the system domain
    wire cfg_type     cfg_src  = {reg_r[12:4], reg_r.elastic_sel};
    wire logic [10:0] cfg_agr  = ~(cfg_s2_r ^ cfg_s3_r);
    wire cfg_type     cfg_nxt  = (cfg_s3_r & cfg_agr)
                               | (cfg_l_r & ~cfg_agr);

    // mode decode: rgmii overrides, then bit five
    wire mode_type    mode_nxt = cfg_l_r.rgmii_mode ? MODE_RGMII :
                                 cfg_l_r.rmii_mode  ? MODE_RMII  :
                                 MODE_MII;
    // bypass only in rmii with bit six low
    wire logic        bypass_nxt = (mode_nxt == MODE_RMII)
                                 & ~cfg_l_r.fifo_normal;

    // carrier/data valid per rmii revision
    always_comb begin
        crs_dv_nxt = 1'b0;
        if (i_link_crs) begin
            crs_dv_nxt = 1'b1;
        end else if (i_link_rx_dv) begin
            crs_dv_nxt = cfg_l_r.rev_1p0 ? 1'b1 : ~crs_dv_r;
        end
    end

    // reset and config synchronisers; bits settle individually
    always_ff @(posedge i_link_clk) begin
        rst_l_s_r <= {rst_l_s_r[1:0], i_rst};
        if (rst_l_s_r[1] == rst_l_s_r[2]) begin
            rst_l_r <= rst_l_s_r[2];
        end
        cfg_s1_r <= cfg_src;
        cfg_s2_r <= cfg_s1_r;
        cfg_s3_r <= cfg_s2_r;
    end

    // link facing outputs, all registered
    always_ff @(posedge i_link_clk) begin
        if (rst_l_r) begin
            cfg_l_r         <= REG_RESET[12:2] == 11'h0 ? '0 :
                               {REG_RESET[12:4], REG_RESET[1:0]};
            link_tgl_r      <= 2'h0;
            mode_r          <= MODE_MII;
            rx_shift_r      <= 1'b0;
            tx_shift_r      <= 1'b1;
            shared_r        <= 1'b0;
            rmii_tx_shift_r <= 1'b0;
            ref50_r         <= 1'b0;
            bypass_r        <= 1'b0;
            clk50_r         <= 1'b0;
            crs_dv_r        <= 1'b0;
            tol_r           <= TOL_SEL_01;
        end else begin
            cfg_l_r         <= cfg_nxt;
            // status events cross as toggles
            link_tgl_r      <= link_tgl_r ^ {i_link_ovf, i_link_udf};
            mode_r          <= mode_nxt;
            rx_shift_r      <= cfg_l_r.rx_clk_shift;
            tx_shift_r      <= ~cfg_l_r.tx_clk_shift_off;
            shared_r        <= cfg_l_r.shared_clk;
            rmii_tx_shift_r <= cfg_l_r.rmii_tx_shift;
            ref50_r         <= cfg_l_r.ref_clk_50m;
            bypass_r        <= bypass_nxt;
            // 50 mhz rx clock while bypassed
            clk50_r         <= bypass_nxt;
            crs_dv_r        <= crs_dv_nxt;
            tol_r           <= tol_bits(cfg_l_r.elastic_sel);
        end
    end

    assign o_if_mode              = mode_r;
    assign o_rx_clk_shift_en      = rx_shift_r;
    assign o_tx_clk_shift_en      = tx_shift_r;
    assign o_rgmii_shared_clk     = shared_r;
    assign o_rmii_tx_clk_shift_en = rmii_tx_shift_r;
    assign o_ref_clk_50m          = ref50_r;
    assign o_rx_fifo_bypass       = bypass_r;
    assign o_rx_clk_50m_out       = clk50_r;
    assign o_crs_dv               = crs_dv_r;
    assign o_elastic_tol_bits     = tol_r;

    // ---------------- checks ----------------
    sequence apb_setup_s;
        i_psel && !i_penable;
    endsequence

    sequence rd_reg_s;
        i_psel && !i_penable && !i_pwrite && hit ##1
        i_psel && i_penable && !i_pwrite && hit;
    endsequence

    bus_answer_a: assert property (@(posedge i_clk) disable iff (i_rst)
        apb_setup_s |=> o_pready)
        else $error("apb access phase not answered in one cycle");

    ovf_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        evt[1] |=> reg_r.ovf)
        else $error("overflow event did not set flag");

    udf_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        evt[0] |=> reg_r.udf)
        else $error("underflow event did not set flag");

    read_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_reg_s ##0 (o_prdata[BIT_OVF] && !evt[1]) |=> !reg_r.ovf)
        else $error("read did not clear reported overflow");

    resv_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_pready |-> o_prdata[31:13] == 19'h0)
        else $error("reserved read bits not zero");

    rmii_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_go |=> reg_r.rmii_mode == $past(i_pwdata[BIT_RMII]))
        else $error("rmii mode bit not written");

    strap_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
        strap_ld && !wr_go |=> reg_r.ref_clk_50m == $past(strap_s3_r[0]))
        else $error("reference strap not captured");

    tx_shift_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        ##1 o_tx_clk_shift_en == !$past(cfg_l_r.tx_clk_shift_off))
        else $error("transmit shift sense wrong");

    mode_sel_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        cfg_l_r.rgmii_mode |=> o_if_mode == MODE_RGMII)
        else $error("rgmii not selected by bit nine");

    bypass_clk_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        o_rx_fifo_bypass |-> o_rx_clk_50m_out && o_if_mode == MODE_RMII)
        else $error("bypass without 50 mhz rx clock");

    crs_hold_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        cfg_l_r.rev_1p0 && (i_link_crs || i_link_rx_dv) |=> o_crs_dv)
        else $error("crs_dv dropped in revision 1.0");

    crs_toggle_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        !cfg_l_r.rev_1p0 && !i_link_crs && i_link_rx_dv
        |=> o_crs_dv != $past(o_crs_dv))
        else $error("crs_dv did not toggle at frame end");

    elastic_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        ##1 o_elastic_tol_bits == tol_bits($past(cfg_l_r.elastic_sel)))
        else $error("elasticity tolerance decode wrong");

    rx_shift_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        ##1 o_rx_clk_shift_en == $past(cfg_l_r.rx_clk_shift))
        else $error("receive shift enable wrong");

    shared_clk_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        ##1 o_rgmii_shared_clk == $past(cfg_l_r.shared_clk))
        else $error("shared clock enable wrong");

    rmii_tx_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        ##1 o_rmii_tx_clk_shift_en == $past(cfg_l_r.rmii_tx_shift))
        else $error("rmii transmit shift wrong");

    ref_clk_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        ##1 o_ref_clk_50m == $past(cfg_l_r.ref_clk_50m))
        else $error("reference clock select wrong");

    rmii_sel_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        !cfg_l_r.rgmii_mode && cfg_l_r.rmii_mode |=> o_if_mode == MODE_RMII)
        else $error("rmii not selected by bit five");

    mii_sel_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        !cfg_l_r.rgmii_mode && !cfg_l_r.rmii_mode |=> o_if_mode == MODE_MII)
        else $error("mii not selected with bit five low");

    bypass_sel_a: assert property (@(posedge i_link_clk) disable iff (rst_l_r)
        !cfg_l_r.rgmii_mode && cfg_l_r.rmii_mode && !cfg_l_r.fifo_normal
        |=> o_rx_fifo_bypass)
        else $error("fifo bypass not taken");

endmodule : mac_interface_mode_config

/* File: sim/mac_link_model.sv */
// link side model: receive fifo events and carrier levels from the far side
module mac_link_model (
    input  wire logic i_link_clk,
    input  wire logic i_ovf_req,
    input  wire logic i_udf_req,
    input  wire logic i_crs_req,
    input  wire logic i_dv_req,
    output logic      o_ovf,
    output logic      o_udf,
    output logic      o_crs,
    output logic      o_dv
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet link until the bench asks for traffic
    initial begin
        {o_ovf, o_udf, o_crs, o_dv} = 4'h0;
    end

    // all link levels change only on the link clock, like the real path
    always @(posedge i_link_clk) begin
        o_ovf <= i_ovf_req;
        o_udf <= i_udf_req;
        o_crs <= i_crs_req;
        o_dv  <= i_dv_req;
    end
endmodule : mac_link_model

/* File: sim/mac_interface_mode_config_tb_top.sv */
// bench for the mac interface mode config register
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
    end end
module mac_interface_mode_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mac_if_cfg_pkg::*;

    logic        clk = 0, lclk = 0, rst = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        s_rg = 0, s_ref = 0;
    logic        ovf_q = 0, udf_q = 0, crs_q = 0, dv_q = 0;
    logic        ovf, udf, crs, dv;
    mode_type    if_mode;
    logic        rxs, txs, shc, rtx, r50, byp, c50, crs_dv, a, b;
    logic [3:0]  tol;
    logic [15:0] cur, wd;
    int          error_cnt = 0, compares = 0;

    // system clock 5 ns; link clock 80 ns with an unrelated phase
    always #2.5 clk = ~clk;
    initial begin
        #13;
        forever #40 lclk = ~lclk;
    end

    mac_link_model peer (.i_link_clk(lclk), .i_ovf_req(ovf_q),
        .i_udf_req(udf_q), .i_crs_req(crs_q), .i_dv_req(dv_q),
        .o_ovf(ovf), .o_udf(udf), .o_crs(crs), .o_dv(dv));

    mac_interface_mode_config dut (.i_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_strap_rgmii(s_rg),
        .i_reference_clock_select_strap(s_ref), .i_link_clk(lclk),
        .i_link_ovf(ovf), .i_link_udf(udf), .i_link_crs(crs),
        .i_link_rx_dv(dv), .o_if_mode(if_mode), .o_rx_clk_shift_en(rxs),
        .o_tx_clk_shift_en(txs), .o_rgmii_shared_clk(shc),
        .o_rmii_tx_clk_shift_en(rtx), .o_ref_clk_50m(r50),
        .o_rx_fifo_bypass(byp), .o_rx_clk_50m_out(c50), .o_crs_dv(crs_dv),
        .o_elastic_tol_bits(tol));

    function automatic logic [3:0] exp_tol(input logic [1:0] s);
        case (s)
            2'h0: return 4'hE;
            2'h1: return 4'h2;
            2'h2: return 4'h6;
            default: return 4'hA;
        endcase
    endfunction : exp_tol

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [15:0] ex);
        apb(1'b0, REG_ADDR, 32'h0);
        `CHK("readback", {16'h0, ex}, rd)
        `CHK("slverr", 1'b0, err)
    endtask : rd_chk

    task automatic do_reset(input logic g, input logic f);
        rst <= 1'b1;
        s_rg <= g;
        s_ref <= f;
        repeat (100) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : do_reset

    // status pulse on the link, then read twice: set, then cleared
    task automatic evt(input int k);
        @(posedge lclk);
        if (k == 0) ovf_q <= 1'b1; else udf_q <= 1'b1;
        @(posedge lclk);
        {ovf_q, udf_q} <= 2'b00;
        repeat (3) @(posedge lclk);
        rd_chk(cur | (k == 0 ? 16'h0008 : 16'h0004));
        rd_chk(cur);
    endtask : evt

    initial begin
        #300000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        void'($urandom(11));
        // strap combinations land in bits 9 and 7 after every reset
        for (int s = 0; s < 4; s++) begin
            do_reset(s[0], s[1]);
            cur = 16'h0041 | (16'(s[0]) << 9) | (16'(s[1]) << 7);
            rd_chk(cur);
            repeat (8) @(posedge lclk);
            `CHK("mode", (s[0] ? MODE_RGMII : MODE_MII), if_mode)
            `CHK("ref50", s[1], r50)
            `CHK("txshift", 1'b1, txs)
        end
        // random writes, corner fields forced so every code is visited
        for (int i = 0; i < 10; i++) begin
            wd = 16'($urandom);
            wd[1:0] = i[1:0];
            wd[5] = i[1];
            wd[9] = i[2] & i[0];
            wd[6] = i[2];
            apb(1'b1, REG_ADDR, {16'($urandom), wd});
            cur = wd & 16'h1FF3;
            rd_chk(cur);
            repeat (8) @(posedge lclk);
            `CHK("rxs", cur[12], rxs)
            `CHK("txs", ~cur[11], txs)
            `CHK("shared", cur[10], shc)
            `CHK("mode", (cur[9] ? MODE_RGMII : cur[5] ? MODE_RMII
                : MODE_MII), if_mode)
            `CHK("rmiitx", cur[8], rtx)
            `CHK("ref50", cur[7], r50)
            `CHK("bypass", ~cur[9] & cur[5] & ~cur[6], byp)
            `CHK("clk50", ~cur[9] & cur[5] & ~cur[6], c50)
            // packet lengths per code are left to software
            `CHK("tol", exp_tol(cur[1:0]), tol)
        end
        // unmapped address is refused and leaves the register alone
        apb(1'b1, REG_ADDR - 8'h04, 32'hFFFF);
        `CHK("wr_err", 1'b1, err)
        apb(1'b0, REG_ADDR + 8'h04, 32'h0);
        `CHK("rd_err", 1'b1, err)
        `CHK("rd_zero", 32'h0, rd)
        rd_chk(cur);
        evt(0);
        evt(1);
        // carrier drop with data pending, both revisions
        for (int r = 0; r < 2; r++) begin
            cur = 16'h0061 | 16'(r << 4);
            apb(1'b1, REG_ADDR, {16'h0, cur});
            repeat (6) @(posedge lclk);
            {crs_q, dv_q} <= 2'b11;
            repeat (4) @(negedge lclk);
            `CHK("crsdv_on", 1'b1, crs_dv)
            {crs_q, dv_q} <= 2'b01;
            repeat (3) @(negedge lclk);
            a = crs_dv;
            @(negedge lclk);
            b = crs_dv;
            `CHK("crsdv_tail", (r == 1), (a & b))
            `CHK("crsdv_tog", (r == 0), (a ^ b))
            {crs_q, dv_q} <= 2'b00;
            repeat (3) @(negedge lclk);
            `CHK("crsdv_off", 1'b0, crs_dv)
        end
        end_of_test();
    end
endmodule : mac_interface_mode_config_tb_top
